/* File: include/cmm_pkg.sv */
// Purpose: Constants shared by the current monitor and multiplexer register bank.
// Assumes: Registers are 8 bits wide and addressed by a small index.
// Notes: Register indices are fixed here and decoded by the register bank.
package cmm_pkg;
    // Register indices.
    localparam logic [1:0] CMM_IDX_CURR_MON = 2'h0;
    localparam logic [1:0] CMM_IDX_REG_SETUP = 2'h1;
    localparam logic [1:0] CMM_IDX_MUX_CTRL = 2'h2;
    // Field positions in the current monitor status register.
    localparam int CMM_LED_BAND_LSB = 0;
    localparam int CMM_IN_BAND_LSB = 2;
    localparam int CMM_DONE_BIT = 4;
    localparam int CMM_START_BIT = 5;
    // Field positions in the regulation setup register.
    localparam int CMM_COMP_LSB = 0;
    localparam int CMM_MODE_LSB = 2;
    // Field positions in the mux control register.
    localparam int CMM_SEL_LSB = 0;
    localparam int CMM_AMUX_BIT = 6;
    localparam int CMM_FSREF_BIT = 7;
    // Reset values.
    localparam logic [1:0] CMM_RST_BAND = 2'h0;
    localparam logic [1:0] CMM_RST_MODE = 2'h1;
    localparam logic [1:0] CMM_RST_COMP = 2'h0;
    localparam logic [5:0] CMM_RST_SEL = 6'h00;
    // Selector code that adds the oscillator clock on the serial output.
    localparam logic [5:0] CMM_SEL_OSC = 6'h04;
endpackage

/* File: rtl/cmm_regs.sv */
// Purpose: Current monitor, regulation mode and internal mux control registers.
// Assumes: A serial front end on sys_clk_in turns frames into index, write strobe and data.
// Notes: Analog status and pin inputs except serial data are synchronised by two flip-flops before use.
// Operation
// - LED current band reads at bits 1:0, read only.
// - Input current band reads at bits 3:2, read only.
// - Done flag at bit 4 sets only on successful monitoring completion; resets 0.
// - Writing start bit as 1 clears the done flag, unless a completion sets it in the same cycle.
// - Regulation mode reads at bits 3:2; reset 01 buck, 10 boost, 11 buck-boost.
// - Compensation level bits 1:0 read/write, reset 00.
// - Six-bit output selector at bits 5:0; zero gives normal serial output.
// - Code 000100 also drives oscillator clock on serial output while select high.
// - Bit 6 enables analog mux output on filter pin; reset 0.
// - Bit 7 connects float switch reference to filter pin; reset 0.
`timescale 1ns/10ps
module cmm_regs (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [1:0] reg_idx_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [1:0] led_band_in,
    input wire logic [1:0] input_band_in,
    input wire logic mon_complete_in,
    input wire logic [1:0] mode_fb_in,
    input wire logic osc_clk_in,
    input wire logic cs_high_in,
    input wire logic spi_sdo_in,
    output logic [7:0] reg_rdata_out,
    output logic mon_start_out,
    output logic [1:0] transition_compensation_level_out,
    output logic [5:0] so_mux_sel_out,
    output logic analog_mux_enable_out,
    output logic float_switch_ref_path_enable_out,
    output logic serial_out
);
    import cmm_pkg::*;

    logic [1:0] led_band_ff;
    logic [1:0] input_band_ff;
    logic monitoring_done_flag_ff;
    logic monitoring_start_bit_ff;
    logic [1:0] mode_ff;
    logic [1:0] mode_prev_ff;
    logic [6:0] meta_ff;
    logic [6:0] sync_ff;
    logic complete_d_ff;
    logic complete_evt;
    logic start_wr;
    logic [7:0] nxt_rdata;

    // Write decode of the start bit written as one.
    function automatic logic start_write(input logic wr, input logic [1:0] idx,
                                         input logic [7:0] d);
        start_write = wr && (idx == CMM_IDX_CURR_MON) && d[CMM_START_BIT];
    endfunction

    assign start_wr = start_write(reg_wr_in, reg_idx_in, reg_wdata_in);
    assign complete_evt = sync_ff[4] && !complete_d_ff;

    // Two-stage synchroniser for the outside inputs other than input band and serial data; only stage two is read.
    // The mode bits reset to the buck code so no illegal mode is seen after reset.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_ff <= {3'h0, CMM_RST_MODE, 2'h0};
            sync_ff <= {3'h0, CMM_RST_MODE, 2'h0};
            complete_d_ff <= 1'b0;
        end else begin
            meta_ff <= {cs_high_in, osc_clk_in, mon_complete_in, mode_fb_in, led_band_in[0],
                        led_band_in[1]};
            sync_ff <= meta_ff;
            complete_d_ff <= sync_ff[4];
        end
    end

    // Separate two-stage synchroniser for the input band code, read only at completion.
    logic [1:0] in_meta_ff;
    logic [1:0] in_sync_ff;
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            in_meta_ff <= CMM_RST_BAND;
            in_sync_ff <= CMM_RST_BAND;
        end else begin
            in_meta_ff <= input_band_in;
            in_sync_ff <= in_meta_ff;
        end
    end

    // Band fields change only on a finished routine, never by a host write.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            led_band_ff <= CMM_RST_BAND;
            input_band_ff <= CMM_RST_BAND;
        end else if (complete_evt) begin
            led_band_ff <= {sync_ff[0], sync_ff[1]};
            input_band_ff <= in_sync_ff;
        end
    end

    // Done flag: completion sets it, a start write clears it, set wins on a tie.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            monitoring_done_flag_ff <= 1'b0;
        end else if (complete_evt) begin
            monitoring_done_flag_ff <= 1'b1;
        end else if (start_wr) begin
            monitoring_done_flag_ff <= 1'b0;
        end
    end

    // Start bit storage and one-cycle launch pulse to the monitoring routine.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            monitoring_start_bit_ff <= 1'b0;
            mon_start_out <= 1'b0;
        end else begin
            if (reg_wr_in && reg_idx_in == CMM_IDX_CURR_MON) begin
                monitoring_start_bit_ff <= reg_wdata_in[CMM_START_BIT];
            end
            mon_start_out <= start_wr;
        end
    end

    // Regulation mode takes a synchronised code only after two equal samples.
    // A two-bit change caught between its bits would otherwise show a false code.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_prev_ff <= CMM_RST_MODE;
            mode_ff <= CMM_RST_MODE;
        end else begin
            mode_prev_ff <= sync_ff[3:2];
            if (sync_ff[3:2] == mode_prev_ff) begin
                mode_ff <= sync_ff[3:2];
            end
        end
    end

    // Read/write control fields.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            transition_compensation_level_out <= CMM_RST_COMP;
            so_mux_sel_out <= CMM_RST_SEL;
            analog_mux_enable_out <= 1'b0;
            float_switch_ref_path_enable_out <= 1'b0;
        end else if (reg_wr_in) begin
            if (reg_idx_in == CMM_IDX_REG_SETUP) begin
                transition_compensation_level_out <= reg_wdata_in[CMM_COMP_LSB +: 2];
            end
            if (reg_idx_in == CMM_IDX_MUX_CTRL) begin
                so_mux_sel_out <= reg_wdata_in[CMM_SEL_LSB +: 6];
                analog_mux_enable_out <= reg_wdata_in[CMM_AMUX_BIT];
                float_switch_ref_path_enable_out <= reg_wdata_in[CMM_FSREF_BIT];
            end
        end
    end

    // Serial output pin: data normally, oscillator clock while select is high on code 4.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            serial_out <= 1'b0;
        end else if (so_mux_sel_out == CMM_SEL_OSC && sync_ff[6]) begin
            serial_out <= sync_ff[5];
        end else begin
            serial_out <= spi_sdo_in;
        end
    end

    // Read data mux, registered; unused index reads zero.
    always_comb begin
        nxt_rdata = 8'h00;
        case (reg_idx_in)
            CMM_IDX_CURR_MON: begin
                nxt_rdata = {2'h0, monitoring_start_bit_ff, monitoring_done_flag_ff,
                             input_band_ff, led_band_ff};
            end
            CMM_IDX_REG_SETUP: begin
                nxt_rdata = {4'h0, mode_ff, transition_compensation_level_out};
            end
            CMM_IDX_MUX_CTRL: begin
                nxt_rdata = {float_switch_ref_path_enable_out, analog_mux_enable_out,
                             so_mux_sel_out};
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    // Read data register; the answer stands one cycle after the index.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= nxt_rdata;
        end
    end

    // Checks.
    a_done_on_complete: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        complete_evt |=> monitoring_done_flag_ff) else $error("done flag not set");
    a_done_cause: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        $rose(monitoring_done_flag_ff) |-> $past(complete_evt)) else $error("done set without cause");
    a_start_clears: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        start_wr && !complete_evt |=> !monitoring_done_flag_ff) else $error("start did not clear");
    a_start_pulse: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        start_wr |=> mon_start_out) else $error("no launch pulse");
    a_band_hold: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        !complete_evt |=> $stable(led_band_ff) && $stable(input_band_ff))
        else $error("band changed without completion");
    a_mode_track: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        sync_ff[3:2] == mode_prev_ff |=> mode_ff == $past(sync_ff[3:2]))
        else $error("mode feedback lost");
    a_mode_settle: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        sync_ff[3:2] != mode_prev_ff |=> $stable(mode_ff))
        else $error("mode took an unsettled code");
    a_done_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        reg_wr_in && reg_idx_in == CMM_IDX_CURR_MON && !start_wr && !complete_evt
        |=> $stable(monitoring_done_flag_ff)) else $error("done flag written by host");
    a_comp_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        reg_wr_in && reg_idx_in == CMM_IDX_REG_SETUP |=> transition_compensation_level_out
        == $past(reg_wdata_in[1:0])) else $error("comp write lost");
    a_mux_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        reg_wr_in && reg_idx_in == CMM_IDX_MUX_CTRL |=> analog_mux_enable_out
        == $past(reg_wdata_in[6]) && float_switch_ref_path_enable_out == $past(reg_wdata_in[7]))
        else $error("mux enables wrong");
    a_so_normal: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        so_mux_sel_out == CMM_RST_SEL |=> serial_out == $past(spi_sdo_in))
        else $error("serial out not data");
    a_so_osc: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        so_mux_sel_out == CMM_SEL_OSC && sync_ff[6] |=> serial_out == $past(sync_ff[5]))
        else $error("oscillator not on serial out");
    a_so_osc_data: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        so_mux_sel_out == CMM_SEL_OSC && !sync_ff[6] |=> serial_out == $past(spi_sdo_in))
        else $error("serial out not data while selected");
endmodule

/* File: sim/cmm_host_model.sv */
// Purpose: Host side model that writes and reads the register bank.
// Assumes: Requests change at the falling edge and are taken at the rising edge.
// Notes: Write data is inverted once the strobe drops, so stale data is never trusted.
`timescale 1ns/10ps
module cmm_host_model (
    input wire logic sys_clk_in,
    input wire logic [7:0] rdata_in,
    output logic [1:0] idx_out,
    output logic wr_out,
    output logic [7:0] wdata_out
);
    // Idle request lines at time zero.
    initial begin
        idx_out = 2'h3;
        wr_out = 1'b0;
        wdata_out = 8'h00;
    end
    // One strobe per write; launching the routine is the host's duty.
    task automatic wr(input logic [1:0] idx, input logic [7:0] d);
        @(negedge sys_clk_in);
        idx_out = idx;
        wdata_out = d;
        wr_out = 1'b1;
        @(negedge sys_clk_in);
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask
    // Read data follows the index one cycle later.
    task automatic rd(input logic [1:0] idx, output logic [7:0] d);
        @(negedge sys_clk_in);
        idx_out = idx;
        @(negedge sys_clk_in);
        d = rdata_in;
    endtask
endmodule

/* File: sim/cmm_regs_tb_top.sv */
// Purpose: Self-checking bench for the monitor and mux register bank.
// Assumes: Inputs change at the falling edge; the host model runs the bus.
// Notes: The oscillator runs unrelated to the system clock.
`timescale 1ns/10ps
module cmm_regs_tb_top;
    import cmm_pkg::*;
    logic sys_clk_in = 1'b0, rstn_in = 1'b0, mon_done = 1'b0;
    logic osc = 1'b0, cs_high = 1'b0, sdo = 1'b0, wr, start, amux, fsref, sout;
    logic [1:0] led_band = 2'h0, in_band = 2'h0, mode_fb = 2'h1, idx, comp;
    logic [7:0] wdata, rdata, got;
    logic [5:0] sel;
    int err_count = 0, num_checks = 0, ones;
    // Clocks.
    always #4 sys_clk_in = ~sys_clk_in;
    always #11 osc = ~osc;
    cmm_host_model i_cmm_host_model (.sys_clk_in(sys_clk_in), .rdata_in(rdata),
        .idx_out(idx), .wr_out(wr), .wdata_out(wdata));
    cmm_regs i_cmm_regs (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_idx_in(idx),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .led_band_in(led_band),
        .input_band_in(in_band), .mon_complete_in(mon_done), .mode_fb_in(mode_fb),
        .osc_clk_in(osc), .cs_high_in(cs_high), .spi_sdo_in(sdo), .reg_rdata_out(rdata),
        .mon_start_out(start), .transition_compensation_level_out(comp),
        .so_mux_sel_out(sel), .analog_mux_enable_out(amux),
        .float_switch_ref_path_enable_out(fsref), .serial_out(sout));
    // Compares one value and counts it.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Counts serial output highs over twelve cycles after settling.
    task automatic count_ones;
        repeat (5) @(negedge sys_clk_in);
        ones = 0;
        repeat (12) begin
            @(negedge sys_clk_in);
            ones += (sout === 1'b1);
        end
    endtask
    // Reset values of all three registers.
    task automatic t_reset;
        i_cmm_host_model.rd(CMM_IDX_CURR_MON, got); chk(got, 8'h00);
        i_cmm_host_model.rd(CMM_IDX_REG_SETUP, got); chk(got, 8'h04);
        i_cmm_host_model.rd(CMM_IDX_MUX_CTRL, got); chk(got, 8'h00);
        chk({sel, amux, fsref}, 8'h00);
    endtask
    // Every level is stored, mode ignores writes, unmapped index is inert.
    task automatic t_ctrl;
        for (int i = 0; i < 4; i++) begin
            i_cmm_host_model.wr(CMM_IDX_REG_SETUP, {4'h0, 2'h2, i[1:0]});
            i_cmm_host_model.rd(CMM_IDX_REG_SETUP, got); chk(got, {6'h01, i[1:0]});
            chk({6'h00, comp}, {6'h00, i[1:0]});
        end
        i_cmm_host_model.wr(CMM_IDX_MUX_CTRL, 8'hC4);
        i_cmm_host_model.rd(CMM_IDX_MUX_CTRL, got); chk(got, 8'hC4);
        chk({sel, amux, fsref}, {CMM_SEL_OSC, 2'h3});
        i_cmm_host_model.wr(2'h3, 8'hFF);
        i_cmm_host_model.rd(2'h3, got); chk(got, 8'h00);
        i_cmm_host_model.rd(CMM_IDX_MUX_CTRL, got); chk(got, 8'hC4);
    endtask
    // Start, completion with band capture, then restart clears done.
    task automatic t_mon;
        led_band = 2'h2;
        in_band = 2'h3;
        i_cmm_host_model.wr(CMM_IDX_CURR_MON, 8'h3F);
        chk({7'h00, start}, 8'h01);
        @(negedge sys_clk_in);
        chk({7'h00, start}, 8'h00);
        i_cmm_host_model.rd(CMM_IDX_CURR_MON, got); chk(got, 8'h20);
        mon_done = 1'b1;
        repeat (6) @(negedge sys_clk_in);
        i_cmm_host_model.rd(CMM_IDX_CURR_MON, got); chk(got, 8'h3E);
        mon_done = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        i_cmm_host_model.wr(CMM_IDX_CURR_MON, 8'h20);
        i_cmm_host_model.rd(CMM_IDX_CURR_MON, got); chk(got, 8'h2E);
    endtask
    // Each regulation mode code shows in the setup register.
    task automatic t_mode;
        for (int m = 1; m < 4; m++) begin
            mode_fb = m[1:0];
            repeat (4) @(negedge sys_clk_in);
            i_cmm_host_model.rd(CMM_IDX_REG_SETUP, got); chk(got, {4'h0, m[1:0], 2'h3});
        end
    endtask
    // Oscillator only with the clock code and chip select high.
    task automatic t_serial;
        count_ones; chk(8'(ones), 8'h00);
        cs_high = 1'b1;
        count_ones; chk({7'h00, ones > 0 && ones < 12}, 8'h01);
        i_cmm_host_model.wr(CMM_IDX_MUX_CTRL, 8'h00);
        count_ones; chk(8'(ones), 8'h00);
        sdo = 1'b1;
        count_ones; chk(8'(ones), 8'h0C);
    endtask
    // Main sequence.
    initial begin
        repeat (3) @(negedge sys_clk_in);
        rstn_in = 1'b1;
        t_reset;
        t_ctrl;
        t_mon;
        t_mode;
        t_serial;
        close_out;
    end
    // Watchdog against a hang.
    initial begin
        #20000;
        err_count++;
        close_out;
    end
endmodule
